/* File: verilog/lcdds_core.sv */
// duty select command and status byte read on the host command bus
//
// Contract
// (RULE1) duty bit high selects 1/32 duty, low selects 1/16 duty
// (RULE2) duty command byte is A8 for low and A9 for high
// (RULE3) host writes commands with select 0, enable 1, read/write 0
// (RULE4) master drives common rows 0 to 15, slave rows 16 to 31; a slave left at 1/16 duty starts at row 0 instead
// (RULE5) host should write duty high in both master and slave
// (RULE6) host reads status with select 0, enable 0, read/write 1
// (RULE7) status carries flags in bits 7 to 4, zeros in bits 3 to 0
// (RULE8) bit 7 is busy while executing a command or resetting
// (RULE9) host sends nothing while busy reads 1
// (RULE10) bit 6 shows column mapping, 1 for inverted
// (RULE11) bit 5 reads 1 when display is off, inverse of setting
// (RULE12) bit 4 reads 1 while the device is being reset
// (RULE13) duty also sets 32 or 16 memory rows mapped to commons
// (RULE14) duty command changes only the duty bit and sets busy
`timescale 1ns/1ps
`include "lcdds_params.svh"
module lcdds_core #(
	parameter int CMD_CYC = `LCDDS_CMD_CYC,
	parameter int RESET_CYC = `LCDDS_RESET_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// host command bus
	input wire logic cmd_data_sel,
	input wire logic enable_read,
	input wire logic read_write,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	// pairing role: 1 for slave half of commons
	input wire logic slave_mode,
	// settings to the panel drive logic
	output logic duty_full,
	output logic [5:0] rows_mapped,
	output logic [4:0] first_common_row,
	output logic seg_inverted,
	output logic display_on
);
	// parameters the eight-bit counter cannot hold are refused at elaboration
	if (CMD_CYC < 1 || CMD_CYC > 255) begin : g_bad_cmd_cyc
		$error("lcdds_core: command busy count out of range");
	end
	if (RESET_CYC < 1 || RESET_CYC > 255) begin : g_bad_reset_cyc
		$error("lcdds_core: reset busy count out of range");
	end

	// sequencer state: reset walk, idle, command in progress
	lcdds_pkg::lcdds_state_type state_r;
	lcdds_pkg::lcdds_state_type state_nxt;
	// cycles left in the current busy stretch
	logic [7:0] count_r;
	logic [7:0] count_nxt;
	// settings written by commands
	logic duty_r;
	logic duty_nxt;
	logic map_r;
	logic map_nxt;
	logic disp_r;
	logic disp_nxt;
	// status byte and its drive enable
	logic [7:0] dout_r;
	logic [7:0] dout_nxt;
	logic oe_r;
	logic oe_nxt;
	// common row window handed to the panel drive
	logic [5:0] rows_r;
	logic [5:0] rows_nxt;
	logic [4:0] first_r;
	logic [4:0] first_nxt;
	// bus decode and the command byte classes
	logic cmd_write;
	logic stat_read;
	logic cmd_taken;
	logic is_duty;
	logic is_map;
	logic is_disp;
	logic [7:0] cmd_class;

	// bus decode; a write while busy or resetting is dropped, the host must poll first
	// limitation: display memory transfers are not served here
	assign cmd_write = !cmd_data_sel && enable_read && !read_write; // RULE3
	assign stat_read = !cmd_data_sel && !enable_read && read_write; // RULE6
	assign cmd_taken = cmd_write && (state_r == lcdds_pkg::LCDDS_IDLE);

	// command byte classes; bit 0 carries the value in all three
	assign cmd_class = data_in & `LCDDS_DUTY_CMD_MASK;
	assign is_duty = (cmd_class == `LCDDS_DUTY_CMD); // RULE2
	assign is_map = (cmd_class == `LCDDS_MAP_CMD);
	assign is_disp = (cmd_class == `LCDDS_DISP_CMD);

	// sequencer next state; the busy stretch is counted down to zero
	always_comb begin
		state_nxt = state_r;
		count_nxt = count_r;
		case (state_r)
			lcdds_pkg::LCDDS_IN_RESET: begin
				// still busy until the reset walk has run out
				if (count_r == 8'h00) begin
					state_nxt = lcdds_pkg::LCDDS_IDLE;
				end else begin
					count_nxt = count_r - 8'h01;
				end
			end
			lcdds_pkg::LCDDS_IDLE: begin
				// every taken byte costs a busy stretch, known or not
				if (cmd_taken) begin
					state_nxt = lcdds_pkg::LCDDS_BUSY; // RULE14
					count_nxt = 8'(CMD_CYC - 1);
				end
			end
			lcdds_pkg::LCDDS_BUSY: begin
				// count ends at zero so the stretch is exactly CMD_CYC edges
				if (count_r == 8'h00) begin
					state_nxt = lcdds_pkg::LCDDS_IDLE;
				end else begin
					count_nxt = count_r - 8'h01;
				end
			end
			default: begin
				// an illegal code recovers to idle rather than hanging busy
				state_nxt = lcdds_pkg::LCDDS_IDLE;
				count_nxt = 8'h00;
			end
		endcase
	end

	// sequencer registers; reset starts the busy reset walk
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r <= lcdds_pkg::LCDDS_IN_RESET;
			count_r <= 8'(RESET_CYC - 1);
		end else begin
			state_r <= state_nxt;
			count_r <= count_nxt;
		end
	end

	// settings; only the addressed bit moves, the others hold
	always_comb begin
		duty_nxt = duty_r;
		map_nxt = map_r;
		disp_nxt = disp_r;
		if (cmd_taken) begin
			if (is_duty) begin
				duty_nxt = data_in[0]; // RULE1 RULE14
			end
			if (is_map) begin
				map_nxt = data_in[0];
			end
			if (is_disp) begin
				disp_nxt = data_in[0];
			end
		end
	end

	// settings registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			duty_r <= `LCDDS_DUTY_RESET;
			map_r <= `LCDDS_MAP_RESET;
			disp_r <= `LCDDS_DISP_RESET;
		end else begin
			duty_r <= duty_nxt;
			map_r <= map_nxt;
			disp_r <= disp_nxt;
		end
	end

	// status byte built from next values, so it agrees with the settings outputs
	// at every edge; the cost is a longer path from the bus to the status flops
	always_comb begin
		dout_nxt = 8'h00; // RULE7
		dout_nxt[`LCDDS_BUSY_BIT] = (state_nxt != lcdds_pkg::LCDDS_IDLE); // RULE8
		dout_nxt[`LCDDS_MAP_BIT] = map_nxt; // RULE10
		dout_nxt[`LCDDS_OFF_BIT] = !disp_nxt; // RULE11
		dout_nxt[`LCDDS_RST_BIT] = (state_nxt == lcdds_pkg::LCDDS_IN_RESET); // RULE12
		// enable follows the read decode one edge late
		oe_nxt = stat_read;
	end

	// status registers; reset shows busy, in reset and display off
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dout_r <= `LCDDS_STATUS_RESET;
			oe_r <= 1'b0;
		end else begin
			dout_r <= dout_nxt;
			oe_r <= oe_nxt;
		end
	end

	// common row window; a slave in a 1/32 pair takes the upper sixteen rows
	always_comb begin
		if (duty_nxt) begin
			rows_nxt = `LCDDS_ROWS_FULL; // RULE13
		end else begin
			rows_nxt = `LCDDS_ROWS_HALF; // RULE13
		end
		// a slave left at 1/16 has no upper half to drive, so it starts at row 0
		if (slave_mode && duty_nxt) begin
			first_nxt = `LCDDS_SLAVE_FIRST_ROW; // RULE4 RULE5
		end else begin
			first_nxt = `LCDDS_MASTER_FIRST_ROW; // RULE4
		end
	end

	// common row window registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rows_r <= `LCDDS_ROWS_FULL;
			first_r <= `LCDDS_MASTER_FIRST_ROW;
		end else begin
			rows_r <= rows_nxt;
			first_r <= first_nxt;
		end
	end

	// every output comes straight from a flip-flop
	assign data_out = dout_r;
	assign data_oe = oe_r;
	assign duty_full = duty_r;
	assign rows_mapped = rows_r;
	assign first_common_row = first_r;
	assign seg_inverted = map_r;
	assign display_on = disp_r;
endmodule : lcdds_core

/* File: verilog/lcdds_params.svh */
// constants for the duty select and status read block
`ifndef LCDDS_PARAMS_SVH
`define LCDDS_PARAMS_SVH
`define LCDDS_DUTY_CMD_MASK 8'hFE
`define LCDDS_DUTY_CMD 8'hA8
`define LCDDS_MAP_CMD 8'hA0
`define LCDDS_DISP_CMD 8'hAE
`define LCDDS_DUTY_RESET 1'b1
`define LCDDS_MAP_RESET 1'b0
`define LCDDS_DISP_RESET 1'b0
`define LCDDS_STATUS_RESET 8'hB0
`define LCDDS_SLAVE_FIRST_ROW 5'h10
`define LCDDS_MASTER_FIRST_ROW 5'h00
`define LCDDS_BUSY_BIT 7
`define LCDDS_MAP_BIT 6
`define LCDDS_OFF_BIT 5
`define LCDDS_RST_BIT 4
`define LCDDS_ROWS_FULL 6'h20
`define LCDDS_ROWS_HALF 6'h10
`define LCDDS_CMD_NS 100
`define LCDDS_CLK_NS 50
`define LCDDS_CMD_CYC ((`LCDDS_CMD_NS + `LCDDS_CLK_NS - 1) / `LCDDS_CLK_NS)
`define LCDDS_RESET_CYC 8
`endif

/* File: verilog/lcdds_pkg.sv */
// types for the duty select and status read block
package lcdds_pkg;
	typedef enum logic [1:0] {LCDDS_IN_RESET, LCDDS_IDLE, LCDDS_BUSY} lcdds_state_type;
endpackage : lcdds_pkg

/* File: sim/lcdds_chk_sva.sv */
// assertions on the duty select block ports
`timescale 1ns/1ps
module lcdds_chk (
	// all ports of the core
	input wire logic clock, rst, cmd_data_sel, enable_read, read_write, data_oe, slave_mode,
	input wire logic duty_full, seg_inverted, display_on,
	input wire logic [7:0] data_in, data_out,
	input wire logic [5:0] rows_mapped,
	input wire logic [4:0] first_common_row
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// a command taken while idle, and its duty form
	sequence s_tk; !cmd_data_sel && enable_read && !read_write && !data_out[7]; endsequence
	sequence s_dy; s_tk ##0 data_in[7:1] == 7'h54; endsequence
	property p_dy; s_dy |=> duty_full == $past(data_in[0]) && $stable(display_on); endproperty
	a_dy: assert property (p_dy) else $error("duty");
	property p_by; s_tk |=> data_out[7] [*2] ##1 !data_out[7]; endproperty
	a_by: assert property (p_by) else $error("busy");
	property p_lo; data_out[3:0] == 4'h0; endproperty
	a_lo: assert property (p_lo) else $error("low bits");
	property p_rw; rows_mapped == (duty_full ? 6'h20 : 6'h10); endproperty
	a_rw: assert property (p_rw) else $error("rows");
	// two quiet cycles, so the registered offset has caught up
	property p_sl; ($stable(slave_mode) && $stable(duty_full)) [*2]
		|-> first_common_row == (slave_mode && duty_full ? 5'h10 : 5'h00); endproperty
	a_sl: assert property (p_sl) else $error("commons");
	property p_mp; data_out[6] == seg_inverted; endproperty
	a_mp: assert property (p_mp) else $error("mapping");
	property p_of; data_out[5] == !display_on; endproperty
	a_of: assert property (p_of) else $error("off");
	property p_rs; $fell(rst) |-> data_out[7] && data_out[4]; endproperty
	a_rs: assert property (p_rs) else $error("reset");
	sequence s_rd; !cmd_data_sel && !enable_read && read_write; endsequence
	property p_oe; s_rd |=> data_oe; endproperty
	a_oe: assert property (p_oe) else $error("read enable");
	property p_nr; !(!cmd_data_sel && !enable_read && read_write) |=> !data_oe; endproperty
	a_nr: assert property (p_nr) else $error("read enable idle");
endmodule : lcdds_chk
bind lcdds_core lcdds_chk u_chk (.*);

/* File: sim/lcdds_host.sv */
// host model on the command bus
`timescale 1ns/1ps
module lcdds_host (
	// from the device
	input wire logic clock,
	input wire logic [7:0] data_out,
	// command bus
	output logic cmd_data_sel = 1'b1, enable_read = 1'b0, read_write = 1'b1,
	output logic [7:0] data_in = 8'h00
);
	// status read held over two edges, status taken settled at the falling edge
	task automatic rd(output logic [7:0] s);
		@(negedge clock);
		{cmd_data_sel, enable_read, read_write} = 3'b001;
		repeat (2) @(posedge clock);
		@(negedge clock);
		s = data_out;
		cmd_data_sel = 1'b1;
	endtask : rd
	// command write; polls busy first unless told to barge in
	task automatic wr(input logic [7:0] b, input bit barge);
		logic [7:0] s;
		s = 8'h80;
		for (int i = 0; i < 20 && s[7] && !barge; i++) rd(s);
		@(negedge clock);
		{cmd_data_sel, enable_read, read_write} = 3'b010;
		data_in = b;
		@(negedge clock);
		{cmd_data_sel, enable_read, read_write} = 3'b101;
		data_in = ~b; // released bus is not left showing the byte
	endtask : wr
endmodule : lcdds_host

/* File: sim/tb_top.sv */
// self-checking bench for the duty select block
`timescale 1ns/1ps
module tb_top;
	logic clock = 1'b0, rst = 1'b1, slave_mode = 1'b0, cmd_data_sel, enable_read, read_write;
	logic data_oe, duty_full, seg_inverted, display_on;
	logic [7:0] data_in, data_out, s, b;
	logic [5:0] rows_mapped;
	logic [4:0] first_common_row;
	logic [31:0] rnd = 32'h8EBE;
	int n_mismatch = 0, cmp_count = 0, cyc = 0, duty = 1, map = 0, disp = 0;
	lcdds_core DUT (.*);
	lcdds_host host (.*);
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	endfunction : xs
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict
	// one command through the model, then the device compared with it
	task automatic step(input logic [7:0] c);
		host.wr(c, 1'b0);
		if (c[7:1] == 7'h54) duty = c[0];
		if (c[7:1] == 7'h50) map = c[0];
		if (c[7:1] == 7'h57) disp = c[0];
		chk("busy", 8'(data_out[7]), 8'h01);
		chk("duty", 8'(duty_full), 8'(duty));
		chk("rows", 8'(rows_mapped), duty ? 8'h20 : 8'h10);
		chk("mapping out", 8'(seg_inverted), 8'(map));
		chk("display out", 8'(display_on), 8'(disp));
		chk("read enable", 8'(data_oe), 8'h00);
		s = 8'h80;
		for (int k = 0; k < 9 && s[7]; k++) host.rd(s);
		chk("status", s, {1'b0, map[0], ~disp[0], 5'h00});
		chk("first", 8'(first_common_row), (slave_mode && duty) ? 8'h10 : 8'h00);
	endtask : step
	initial forever #25 clock = ~clock;
	// a hang ends the run as a mismatch
	always @(posedge clock) if (++cyc == 9000) begin
		n_mismatch++;
		give_verdict();
	end
	initial begin
		repeat (10) @(posedge clock);
		@(negedge clock) rst = 1'b0;
		host.wr(8'hA8, 1'b1); // write while still resetting is dropped
		chk("in reset", data_out & 8'h90, 8'h90);
		chk("dropped", 8'(duty_full), 8'h01);
		for (int i = 0; i < 24; i++) begin
			rnd = xs(rnd);
			b = 8'hA0 | {4'h0, rnd[1:0] == 2'b00, rnd[0] & rnd[1], 1'b0, rnd[4]};
			if (b[2] && rnd[5]) b = b ^ 8'h0A;
			slave_mode = rnd[7];
			step(b);
		end
		slave_mode = 1'b1;
		step(8'hA8);
		step(8'hA9);
		give_verdict();
	end
endmodule : tb_top
